//--- hdl/sisc_pkg.sv
// Package: constants, types and helpers of the interrupt and standby control block
package sisc_pkg;

   // ----------------------------------------------------------------
   // Frame layout and register selection
   // ----------------------------------------------------------------
   localparam int SEL_MSB = 15;
   localparam int SEL_LSB = 13;
   localparam logic [2:0] SEL_CTRL = 3'h2;
   localparam logic [2:0] SEL_STAT = 3'h3;

   // ----------------------------------------------------------------
   // Control register fields
   // ----------------------------------------------------------------
   localparam int BIT_LOCK = 12;
   localparam int BIT_MAIN_UV_EN = 11;
   localparam int BIT_AUX_UV_EN = 10;
   localparam int BIT_LIN_STBY = 9;
   localparam int WAKE_A_MSB = 7;
   localparam int WAKE_A_LSB = 6;
   localparam int WAKE_B_MSB = 5;
   localparam int WAKE_B_LSB = 4;
   localparam int BIT_CAN_STBY = 3;
   localparam logic [15:0] CTRL_WR_MASK = 16'h1EF8;
   localparam logic [15:0] CTRL_RESET = 16'h0000;

   // ----------------------------------------------------------------
   // Status register flags
   // ----------------------------------------------------------------
   localparam int BIT_MAIN_UV_FLAG = 11;
   localparam int BIT_AUX_UV_FLAG = 10;
   localparam int BIT_LIN_WAKE_FLAG = 9;
   localparam int BIT_WAKE_A_FLAG = 6;
   localparam int BIT_WAKE_B_FLAG = 4;
   localparam int BIT_CAN_WAKE_FLAG = 3;
   localparam logic [15:0] STAT_FLAG_MASK = 16'h0E58;
   localparam logic [15:0] STAT_RESET = 16'h0000;

   // ----------------------------------------------------------------
   // Wake input edge selection
   // ----------------------------------------------------------------
   localparam logic [1:0] EDGE_NONE = 2'h0;
   localparam logic [1:0] EDGE_RISE = 2'h1;
   localparam logic [1:0] EDGE_FALL = 2'h2;
   localparam logic [1:0] EDGE_BOTH = 2'h3;

   // Chip operating mode
   typedef enum logic [1:0] {
      MODE_STANDBY = 2'h0,
      MODE_SLEEP = 2'h1,
      MODE_NORMAL_AUX_OFF = 2'h2,
      MODE_NORMAL_AUX_ON = 2'h3
   } sisc_mode_t;

   // Transceiver state, Gray ordered off -> active -> low power
   typedef enum logic [1:0] {
      XCVR_OFF = 2'h0,
      XCVR_ACTIVE = 2'h1,
      XCVR_LOWPWR = 2'h3
   } sisc_xcvr_t;

   // Both Normal codes share the upper bit
   function automatic logic is_normal(input logic [1:0] mode);
      return (mode == MODE_NORMAL_AUX_OFF) || (mode == MODE_NORMAL_AUX_ON);
   endfunction

   // Edge match for a wake input against its selection
   function automatic logic edge_hit(input logic [1:0] sel, input logic prev,
                                     input logic cur);
      logic rise;
      logic fall;
      rise = !prev && cur;
      fall = prev && !cur;
      case (sel)
         EDGE_RISE: return rise;
         EDGE_FALL: return fall;
         EDGE_BOTH: return rise || fall;
         default: return 1'b0;
      endcase
   endfunction

endpackage

//--- hdl/sisc_edge_if.sv
// Interface: wake input level, edge selection and detected hit
`timescale 1ns/10ps
interface sisc_edge_if;
   logic [1:0] sel;
   logic level;
   logic hit;
   modport det (input sel, input level, output hit);
   modport ctl (output sel, output level, input hit);
endinterface

//--- hdl/sisc_wake_edge.sv
// Module: edge detector for one local wake input
`timescale 1ns/10ps
module sisc_wake_edge
   import sisc_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic reset,
   // Wake input link
   sisc_edge_if.det eif
);

   logic prev_r;

   // Previous input level
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         prev_r <= 1'b0;
      end else begin
         prev_r <= eif.level;
      end
   end

   // Hit on the selected edge
   assign eif.hit = edge_hit(eif.sel, prev_r, eif.level); // [RULE7] [RULE8]

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   chk_rise_edge_hit: assert property (@(posedge ref_clk) disable iff (reset) // [RULE7]
      (eif.sel == EDGE_RISE && $stable(eif.sel) && $rose(eif.level)) |-> eif.hit)
      else $error("rising edge missed");
   chk_fall_edge_hit: assert property (@(posedge ref_clk) disable iff (reset) // [RULE8]
      (eif.sel == EDGE_FALL && $stable(eif.sel) && $fell(eif.level)) |-> eif.hit)
      else $error("falling edge missed");
   chk_disabled_no_hit: assert property (@(posedge ref_clk) disable iff (reset) // [RULE7]
      (eif.sel == EDGE_NONE) |-> !eif.hit)
      else $error("hit while disabled");

endmodule // sisc_wake_edge

//--- hdl/sisc_ctrl.sv
// Module: interrupt enable and transceiver standby control register
`timescale 1ns/10ps

// Operation
// [RULE1] Control writes apply while lock is 0; once lock is 1 they are ignored.
// [RULE2] Main supply undervoltage flag may set only while its enable is 1.
// [RULE3] Aux supply undervoltage flag may set only while its enable is 1.
// [RULE4] LIN standby 0 in Normal: LIN active, LIN wake flag cleared.
// [RULE5] LIN standby 0 in Standby/Sleep: LIN off, no wake detection or flag.
// [RULE6] LIN standby 1: LIN low power, wake detection on, any mode.
// [RULE7] Wake input A field picks none, rising, falling or both edges.
// [RULE8] Wake input B field uses the same edge encoding.
// [RULE9] CAN standby 0 in Normal: CAN active, CAN wake flag cleared.
// [RULE10] CAN standby 0 in Standby/Sleep: CAN off, no wake detection or flag.
// [RULE11] CAN standby 1: CAN low power, wake detection on, any mode.
// [RULE12] All control fields reset to zero.
// [RULE13] Mode 00 Standby, 01 Sleep, 10 Normal aux off, 11 Normal aux on.
// [RULE14] Writing 1 to a status flag clears it; 0 leaves it.
// [RULE15] An enabled event sets its flag, which stays until cleared.
module sisc_ctrl
   import sisc_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic reset,
   // Serial frame write strobe
   input wire logic frame_stb,
   input wire logic [15:0] frame_word,
   // Chip state and events
   input wire logic [1:0] chip_mode_field,
   input wire logic main_supply_uv,
   input wire logic aux_supply_uv,
   input wire logic wake_in_a,
   input wire logic wake_in_b,
   input wire logic lin_bus_wake,
   input wire logic can_bus_wake,
   // Read back words
   output logic [15:0] ctrl_rd_word,
   output logic [15:0] stat_rd_word,
   // Transceiver control
   output logic [1:0] lin_xcvr_mode,
   output logic [1:0] can_xcvr_mode,
   output logic lin_wake_det_en,
   output logic can_wake_det_en,
   output logic lin_wake_flag_clr,
   output logic can_wake_flag_clr,
   output logic irq_pending
);

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   logic [15:0] ctrl_r;
   logic [15:0] stat_r;
   logic [15:0] stat_nxt;
   logic [15:0] set_vec;
   logic [15:0] clr_vec;
   logic main_uv_prev_r;
   logic aux_uv_prev_r;
   logic ctrl_wr;
   logic stat_wr;
   logic chip_normal;
   sisc_xcvr_t lin_nxt;
   sisc_xcvr_t can_nxt;
   sisc_edge_if wake_a_if();
   sisc_edge_if wake_b_if();

   // Frame decode
   assign ctrl_wr = frame_stb && (frame_word[SEL_MSB:SEL_LSB] == SEL_CTRL);
   assign stat_wr = frame_stb && (frame_word[SEL_MSB:SEL_LSB] == SEL_STAT);
   assign chip_normal = is_normal(chip_mode_field); // [RULE13]

   // ----------------------------------------------------------------
   // Wake input edge detectors
   // ----------------------------------------------------------------
   assign wake_a_if.sel = ctrl_r[WAKE_A_MSB:WAKE_A_LSB]; // [RULE7]
   assign wake_a_if.level = wake_in_a;
   assign wake_b_if.sel = ctrl_r[WAKE_B_MSB:WAKE_B_LSB]; // [RULE8]
   assign wake_b_if.level = wake_in_b;

   sisc_wake_edge u_wake_a (
      .ref_clk(ref_clk),
      .reset(reset),
      .eif(wake_a_if.det)
   );

   sisc_wake_edge u_wake_b (
      .ref_clk(ref_clk),
      .reset(reset),
      .eif(wake_b_if.det)
   );

   // ----------------------------------------------------------------
   // Control register
   // ----------------------------------------------------------------

   // Writable only while unlocked
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         ctrl_r <= CTRL_RESET; // [RULE12]
      end else if (ctrl_wr && !ctrl_r[BIT_LOCK]) begin // [RULE1]
         ctrl_r <= frame_word & CTRL_WR_MASK;
      end
   end

   // ----------------------------------------------------------------
   // Status flags
   // ----------------------------------------------------------------

   // Supply warning previous levels
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         main_uv_prev_r <= 1'b0;
         aux_uv_prev_r <= 1'b0;
      end else begin
         main_uv_prev_r <= main_supply_uv;
         aux_uv_prev_r <= aux_supply_uv;
      end
   end

   // Gated event sources and write-one clears
   always_comb begin
      set_vec = 16'h0000;
      set_vec[BIT_MAIN_UV_FLAG] = ctrl_r[BIT_MAIN_UV_EN] && main_supply_uv
                                  && !main_uv_prev_r; // [RULE2]
      set_vec[BIT_AUX_UV_FLAG] = ctrl_r[BIT_AUX_UV_EN] && aux_supply_uv
                                 && !aux_uv_prev_r; // [RULE3]
      set_vec[BIT_LIN_WAKE_FLAG] = ctrl_r[BIT_LIN_STBY] && lin_bus_wake; // [RULE5] [RULE6]
      set_vec[BIT_WAKE_A_FLAG] = wake_a_if.hit;
      set_vec[BIT_WAKE_B_FLAG] = wake_b_if.hit;
      set_vec[BIT_CAN_WAKE_FLAG] = ctrl_r[BIT_CAN_STBY] && can_bus_wake; // [RULE10] [RULE11]
      clr_vec = stat_wr ? frame_word : 16'h0000; // [RULE14]
      stat_nxt = ((stat_r & ~clr_vec) | set_vec) & STAT_FLAG_MASK; // [RULE15]
   end

   // Sticky flags, set wins over clear
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         stat_r <= STAT_RESET;
      end else begin
         stat_r <= stat_nxt; // [RULE15]
      end
   end

   // ----------------------------------------------------------------
   // Transceiver state
   // ----------------------------------------------------------------

   // Standby bit overrides mode; else mode chooses active or off
   always_comb begin
      if (ctrl_r[BIT_LIN_STBY]) begin
         lin_nxt = XCVR_LOWPWR; // [RULE6]
      end else if (chip_normal) begin
         lin_nxt = XCVR_ACTIVE; // [RULE4]
      end else begin
         lin_nxt = XCVR_OFF; // [RULE5]
      end
      if (ctrl_r[BIT_CAN_STBY]) begin
         can_nxt = XCVR_LOWPWR; // [RULE11]
      end else if (chip_normal) begin
         can_nxt = XCVR_ACTIVE; // [RULE9]
      end else begin
         can_nxt = XCVR_OFF; // [RULE10]
      end
   end

   // Registered outputs
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         lin_xcvr_mode <= XCVR_OFF;
         can_xcvr_mode <= XCVR_OFF;
         lin_wake_det_en <= 1'b0;
         can_wake_det_en <= 1'b0;
         lin_wake_flag_clr <= 1'b0;
         can_wake_flag_clr <= 1'b0;
      end else begin
         lin_xcvr_mode <= lin_nxt;
         can_xcvr_mode <= can_nxt;
         lin_wake_det_en <= (lin_nxt == XCVR_LOWPWR); // [RULE6]
         can_wake_det_en <= (can_nxt == XCVR_LOWPWR); // [RULE11]
         lin_wake_flag_clr <= (lin_nxt == XCVR_ACTIVE); // [RULE4]
         can_wake_flag_clr <= (can_nxt == XCVR_ACTIVE); // [RULE9]
      end
   end

   // Read back words and summary request
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         ctrl_rd_word <= 16'h0000;
         stat_rd_word <= 16'h0000;
         irq_pending <= 1'b0;
      end else begin
         ctrl_rd_word <= {SEL_CTRL, ctrl_r[12:0]};
         stat_rd_word <= {SEL_STAT, stat_r[12:0]};
         irq_pending <= |stat_r;
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (reset);

   chk_lock_holds_ctrl: assert property ((ctrl_r[BIT_LOCK] && ctrl_wr) |=> // [RULE1]
      $stable(ctrl_r)) else $error("locked register changed");
   chk_main_uv_gate: assert property ($rose(stat_r[BIT_MAIN_UV_FLAG]) |-> // [RULE2]
      $past(ctrl_r[BIT_MAIN_UV_EN])) else $error("main uv flag while disabled");
   chk_aux_uv_gate: assert property ($rose(stat_r[BIT_AUX_UV_FLAG]) |-> // [RULE3]
      $past(ctrl_r[BIT_AUX_UV_EN])) else $error("aux uv flag while disabled");
   chk_lin_normal_active: assert property ((!ctrl_r[BIT_LIN_STBY] && chip_normal) |=> // [RULE4]
      (lin_xcvr_mode == XCVR_ACTIVE && lin_wake_flag_clr && !lin_wake_det_en))
      else $error("lin not active in normal");
   chk_lin_off_quiet: assert property ((!ctrl_r[BIT_LIN_STBY] && !chip_normal) |=> // [RULE5]
      (lin_xcvr_mode == XCVR_OFF && !lin_wake_det_en)) else $error("lin not off");
   chk_lin_no_wake: assert property ($rose(stat_r[BIT_LIN_WAKE_FLAG]) |-> // [RULE5]
      $past(ctrl_r[BIT_LIN_STBY])) else $error("lin wake flag while off");
   chk_lin_lowpower: assert property (ctrl_r[BIT_LIN_STBY] |=> // [RULE6]
      (lin_xcvr_mode == XCVR_LOWPWR && lin_wake_det_en)) else $error("lin not low power");
   chk_can_normal_active: assert property ((!ctrl_r[BIT_CAN_STBY] && chip_normal) |=> // [RULE9]
      (can_xcvr_mode == XCVR_ACTIVE && can_wake_flag_clr)) else $error("can not active");
   chk_can_off_quiet: assert property ((!ctrl_r[BIT_CAN_STBY] && !chip_normal) |=> // [RULE10]
      (can_xcvr_mode == XCVR_OFF && !can_wake_det_en && !$rose(stat_r[BIT_CAN_WAKE_FLAG])))
      else $error("can not off");
   chk_can_lowpower: assert property (ctrl_r[BIT_CAN_STBY] |=> // [RULE11]
      (can_xcvr_mode == XCVR_LOWPWR && can_wake_det_en)) else $error("can not low power");
   chk_reset_zero: assert property (@(posedge ref_clk) $past(reset) |-> // [RULE12]
      (ctrl_r == CTRL_RESET)) else $error("control not zero after reset");
   chk_wake_a_flag: assert property (wake_a_if.hit |=> stat_r[BIT_WAKE_A_FLAG]) // [RULE7]
      else $error("wake a flag missed");
   chk_flag_clear: assert property ((stat_wr && frame_word[BIT_CAN_WAKE_FLAG] // [RULE14]
      && !set_vec[BIT_CAN_WAKE_FLAG]) |=> !stat_r[BIT_CAN_WAKE_FLAG])
      else $error("flag not cleared");
   chk_flag_sticky: assert property ((stat_r[BIT_WAKE_B_FLAG] && !(stat_wr // [RULE15]
      && frame_word[BIT_WAKE_B_FLAG])) |=> stat_r[BIT_WAKE_B_FLAG])
      else $error("flag dropped");
   chk_irq_follows: assert property ((|stat_r) |=> irq_pending) // [RULE15]
      else $error("summary request missing");

   cov_lock_set: cover property ($rose(ctrl_r[BIT_LOCK]));
   cov_lin_wake: cover property ($rose(stat_r[BIT_LIN_WAKE_FLAG]));
   cov_wake_both: cover property ((wake_b_if.sel == EDGE_BOTH) && wake_b_if.hit);
   cov_set_clear_same: cover property (stat_wr && |(set_vec & frame_word));

endmodule // sisc_ctrl

//--- test/sisc_host_model.sv
// Host side model: issues register frames to the control block
`timescale 1ns/10ps
module sisc_host_model
   import sisc_pkg::*;
(
   // Clock
   input wire logic ref_clk,
   // Frame strobe and word
   output logic frame_stb,
   output logic [15:0] frame_word
);
   // ----------------------------------------------------------------
   // Idle state
   // ----------------------------------------------------------------
   initial begin
      frame_stb = 1'b0;
      frame_word = 16'h0000;
   end

   // One frame; word scrambled once the strobe drops
   task automatic send(input logic [2:0] sel, input logic [12:0] data);
      @(posedge ref_clk);
      frame_stb <= 1'b1;
      frame_word <= {sel, data};
      @(posedge ref_clk);
      frame_stb <= 1'b0;
      frame_word <= ~{sel, data};
   endtask

   // Control write, dropped by the block while locked
   task automatic write_ctrl(input logic [12:0] data);
      send(SEL_CTRL, data);
   endtask

   // Status write, ones clear flags
   task automatic clear_stat(input logic [12:0] data);
      send(SEL_STAT, data);
   endtask
endmodule // sisc_host_model

//--- test/sbc_interrupt_standby_control_tb.sv
// Testbench: control register, flags and transceiver standby outputs
`timescale 1ns/10ps
module sbc_interrupt_standby_control_tb import sisc_pkg::*;;
   logic ref_clk, reset, frame_stb, main_supply_uv, aux_supply_uv;
   logic wake_in_a, wake_in_b, lin_bus_wake, can_bus_wake, irq_pending;
   logic lin_wake_det_en, can_wake_det_en, lin_wake_flag_clr, can_wake_flag_clr;
   logic [1:0] chip_mode_field, lin_xcvr_mode, can_xcvr_mode;
   logic [15:0] frame_word, ctrl_rd_word, stat_rd_word;
   logic [15:0] xcvr_word;
   int n_errors = 0;
   int n_compared = 0;
   int cycles = 0;

   // ----------------------------------------------------------------
   // Design and host
   // ----------------------------------------------------------------
   sisc_ctrl dut_u (.ref_clk(ref_clk), .reset(reset), .frame_stb(frame_stb),
      .frame_word(frame_word), .chip_mode_field(chip_mode_field),
      .main_supply_uv(main_supply_uv), .aux_supply_uv(aux_supply_uv),
      .wake_in_a(wake_in_a), .wake_in_b(wake_in_b), .lin_bus_wake(lin_bus_wake),
      .can_bus_wake(can_bus_wake), .ctrl_rd_word(ctrl_rd_word),
      .stat_rd_word(stat_rd_word), .lin_xcvr_mode(lin_xcvr_mode),
      .can_xcvr_mode(can_xcvr_mode), .lin_wake_det_en(lin_wake_det_en),
      .can_wake_det_en(can_wake_det_en), .lin_wake_flag_clr(lin_wake_flag_clr),
      .can_wake_flag_clr(can_wake_flag_clr), .irq_pending(irq_pending));
   sisc_host_model host_u (.ref_clk(ref_clk), .frame_stb(frame_stb),
      .frame_word(frame_word));

   // Transceiver outputs packed in the order of xword
   assign xcvr_word = {8'h00, lin_xcvr_mode, can_xcvr_mode,
      lin_wake_det_en, can_wake_det_en, lin_wake_flag_clr, can_wake_flag_clr};

   // Clock
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   // Hang guard
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 5000) begin
         n_errors++;
         $display("mismatch at %0t: run did not finish", $time);
         final_report();
      end
   end

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   task automatic final_report();
      $display("compared %0d, errors %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic cmp(input logic [15:0] got, input logic [15:0] exp, input string what);
      n_compared++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask

   // Expected transceiver state from standby bit and mode
   function automatic logic [1:0] xexp(input logic stby, input logic [1:0] mode);
      return stby ? XCVR_LOWPWR : (mode[1] ? XCVR_ACTIVE : XCVR_OFF);
   endfunction

   function automatic logic [15:0] xword(input logic [1:0] l, input logic [1:0] c);
      return {8'h00, l, c, l == XCVR_LOWPWR, c == XCVR_LOWPWR, l == XCVR_ACTIVE,
         c == XCVR_ACTIVE};
   endfunction

   task automatic set_wake(input int ch, input logic v);
      @(posedge ref_clk);
      if (ch == 1) wake_in_b <= v;
      else wake_in_a <= v;
      tick(3);
   endtask

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      reset = 1'b1;
      chip_mode_field = 2'h0;
      {main_supply_uv, aux_supply_uv, wake_in_a, wake_in_b} = 4'h0;
      {lin_bus_wake, can_bus_wake} = 2'h0;
      repeat (16) @(posedge ref_clk);
      reset <= 1'b0;
      tick(3);
      cmp(ctrl_rd_word, 16'h4000, "ctrl after reset");
      cmp(stat_rd_word, 16'h6000, "stat after reset");
      // Every mode with both standby settings, bus wake pulsed
      for (int s = 0; s < 2; s++) begin
         host_u.write_ctrl(s ? 13'h0208 : 13'h0000);
         for (int m = 0; m < 4; m++) begin
            logic [15:0] xe;
            @(posedge ref_clk);
            chip_mode_field <= m[1:0];
            {lin_bus_wake, can_bus_wake} <= 2'h3;
            @(posedge ref_clk);
            {lin_bus_wake, can_bus_wake} <= 2'h0;
            tick(3);
            xe = xword(xexp(s[0], m[1:0]), xexp(s[0], m[1:0]));
            cmp(xcvr_word & 16'h00CA, xe & 16'h00CA, "lin");
            cmp(xcvr_word & 16'h0035, xe & 16'h0035, "can");
            cmp(stat_rd_word, s ? 16'h6208 : 16'h6000, "bus wake");
            host_u.clear_stat(13'h0000);
            tick(3);
            cmp(stat_rd_word, s ? 16'h6208 : 16'h6000, "zero write");
            host_u.clear_stat(13'h0208);
            tick(3);
            cmp(stat_rd_word, 16'h6000, "flag clear");
         end
      end
      // Undervoltage rise, disabled then enabled
      for (int e = 0; e < 2; e++) begin
         host_u.write_ctrl(e ? 13'h0C00 : 13'h0000);
         @(posedge ref_clk);
         {main_supply_uv, aux_supply_uv} <= 2'h3;
         @(posedge ref_clk);
         {main_supply_uv, aux_supply_uv} <= 2'h0;
         tick(3);
         cmp(stat_rd_word, e ? 16'h6C00 : 16'h6000, "uv flags");
         cmp({15'h0000, irq_pending}, e ? 16'h0001 : 16'h0000, "irq");
         host_u.clear_stat(13'h0C00);
         tick(3);
      end
      // Wake inputs A and B, every edge selection
      for (int ch = 0; ch < 2; ch++) begin
         for (int sl = 0; sl < 4; sl++) begin
            logic [15:0] fl;
            fl = ch ? 16'h0010 : 16'h0040;
            host_u.write_ctrl(13'(sl[1:0]) << (ch ? 4 : 6));
            set_wake(ch, 1'b1);
            cmp(stat_rd_word, 16'h6000 | (sl[0] ? fl : 16'h0000), "rise");
            host_u.clear_stat(fl[12:0]);
            set_wake(ch, 1'b0);
            cmp(stat_rd_word, 16'h6000 | (sl[1] ? fl : 16'h0000), "fall");
            host_u.clear_stat(fl[12:0]);
            tick(3);
         end
      end
      // Lock with all bits, then a write that must be dropped
      host_u.write_ctrl(13'h1FFF);
      tick(3);
      cmp(ctrl_rd_word, 16'h5EF8, "lock write");
      host_u.write_ctrl(13'h0000);
      tick(3);
      cmp(ctrl_rd_word, 16'h5EF8, "locked");
      // Reset in mid run clears the lock and every field
      @(posedge ref_clk);
      reset <= 1'b1;
      repeat (2) @(posedge ref_clk);
      reset <= 1'b0;
      tick(3);
      cmp(ctrl_rd_word, 16'h4000, "ctrl after second reset");
      cmp(stat_rd_word, 16'h6000, "stat after second reset");
      cmp(xcvr_word, 16'h0053, "xcvr after second reset");
      host_u.write_ctrl(13'h0200);
      tick(3);
      cmp(ctrl_rd_word, 16'h4200, "unlocked after reset");
      final_report();
   end
endmodule // sbc_interrupt_standby_control_tb
